/* File: pkg/tes_regs.svh */
// Register offsets, field positions, reset values and codes of the tape extended status bank.
`ifndef TES_REGS_SVH
`define TES_REGS_SVH

`define TES_OFF_MAIN_STATUS    8'h00
`define TES_OFF_RESIDUAL       8'h04
`define TES_OFF_XST0           8'h08
`define TES_OFF_XST1           8'h0c
`define TES_OFF_XST2           8'h10
`define TES_OFF_XST3           8'h14
`define TES_OFF_CHAR           8'h18
`define TES_OFF_IRQ_STATUS     8'h1c
`define TES_OFF_IRQ_MASK       8'h20

`define TES_X0_TAPE_MARK       15
`define TES_X0_REC_SHORT       14
`define TES_X0_LOGICAL_END     13
`define TES_X0_REC_LONG        12
`define TES_X0_WRITE_LOCK_ERR  11
`define TES_X0_ONLINE          6
`define TES_X0_WRITE_LOCKED    2
`define TES_X0_BOT             1

`define TES_MS_SPECIAL         15
`define TES_MS_TC_LSB          1

`define TES_TC_NORMAL          3'h0
`define TES_TC_ATTENTION       3'h1
`define TES_TC_STATUS_ALERT    3'h2
`define TES_TC_REJECT          3'h3
`define TES_TC_RECOVER_MOVED   3'h4
`define TES_TC_RECOVER_STILL   3'h5
`define TES_TC_UNRECOVERABLE   3'h6
`define TES_TC_FATAL           3'h7

`define TES_RESET_WORD         16'h0000
`define TES_IRQ_BITS           3

`endif

/* File: pkg/tes_pkg.sv */
// Types shared by the tape extended status bank.
package tes_pkg;

    typedef logic [2:0] tes_class_t;

    // One-cycle event report from the tape transport.
    typedef struct packed {
        logic        cmd_start;
        logic        cmd_done;
        logic        tape_mark_seen;
        logic        record_short;
        logic        record_long;
        logic        double_mark;
        logic        first_is_mark;
        logic        skip_cmd;
        logic        write_no_ring;
        logic        write_lock_trip;
        logic        attention;
        logic        offline_reject;
        logic        recover_moved;
        logic        fatal;
        logic        residual_valid;
        logic [15:0] residual;
    } tes_event_t;

    // Slowly changing transport levels and the three detailed status words.
    typedef struct packed {
        logic        online_flag;
        logic        write_locked;
        logic        beginning_of_tape;
        logic [15:0] xst1;
        logic [15:0] xst2;
        logic [15:0] xst3;
    } tes_level_t;

    typedef enum logic [1:0] {
        TES_IDLE = 2'b00,
        TES_BUSY = 2'b01,
        TES_DONE = 2'b11
    } tes_state_t;

endpackage

/* File: src/tes_bank.sv */
// Extended status register bank of a tape subsystem controller behind AXI4-Lite.
`timescale 1ns/10ps
`include "tes_regs.svh"
// How it works
// - Five read-only status words sit beside the main status: residual count and extended status zero to three.
// - Class four reports a recoverable error with the tape one record past the start of the function.
// - Class seven reports a fatal controller error and outranks every other class.
// - Status-only bits are reported without ending the command with a class; only class-tagged bits raise one.
// - The sixteen-bit residual count is loaded after read, space record and skip tape mark commands.
// - The tape mark seen bit is set on a tape mark in read, space, skip or write tape mark and raises class two.
// - The record short bit is set with class two on short reads or early stops of space and skip commands.
// - The logical end bit is set with class two only in skip tape marks on a double mark or a mark after leaving BEGINNING_OF_TAPE.
// - Logical end reporting happens only when software has enabled it through the characteristics register.
// - The record long bit is set with class two when a record exceeds the byte count.
// - The write lock error bit is set with class three on a write without ring and class six on a lock trip.
// - Class one marks an attention through the online flag; class three marks a rejected function.
////////////////////////////////////////////////////////////////////////////////
// Register map, one aligned 32-bit word per register, data in bits 15:0.
//   0x00 main status: bit 15 special condition, bits 3:1 termination class.
//   0x04 residual count, loaded only when the transport reports one.
//   0x08 extended status zero: latched flags in 15:11, live levels in 6, 2, 1.
//   0x0c, 0x10, 0x14 extended status one to three, shown live from the transport.
//   0x18 characteristics: bit 0 enables logical end reporting.
//   0x1c interrupt status, write one to clear.
//   0x20 interrupt mask, same layout as the status.
// Every other address answers with a slave error and reads as zero.
// Writes to the read-only words also answer with a slave error and change nothing.
//
// Transport interface.
//   The transport runs on this clock, so its event pulses are used as they come.
//   A command is framed by a start pulse and a done pulse.
//   Flags latched between them stay until the next start pulse.
//   Outside a command only attention, a residual report and a done pulse's interrupt act; an attention also passes its cycle's other events into the class.
//   Attention may come at any time, since it reports a change of the transport.
//
// Termination class.
//   Within one command the class only grows; a milder event never hides a worse one.
//   A fatal error forces class seven regardless of what came before.
//   The special condition bit mirrors a nonzero class, so software tests one bit first.
//   Status-only levels never reach the class, so they can be polled freely.
//
// Interrupts.
//   Bit 0 marks a finished command, bit 1 an attention, bit 2 a finished command with
//   a nonzero class.
//   A new event wins over a clear in the same cycle, so no event is ever lost; the
//   price is that software may have to clear twice when the two collide.
//
// Bus timing.
//   Address and data may come in either order or together.
//   The write response follows one cycle after both are present.
//   The read answer follows one cycle after the address is taken.
//   Only one write and one read are accepted at a time.
//
// Clock enable.
//   While the enable is low nothing moves, the bus answers included.
//   Reset still acts while the enable is low.
//
// Limitations.
//   The residual is meaningless after commands that do not report one; it keeps the
//   last reported value rather than clearing, so stale counts must be ignored by software.
//   Detailed bits of words one to three are passed through unchanged.
//   A double tape mark in skip counts as a short stop only with logical end enabled.
////////////////////////////////////////////////////////////////////////////////
module tes_bank
    import tes_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         clk_en,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    input  wire tes_event_t   xport_event,
    input  wire tes_level_t   xport_level,
    output logic              irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    tes_state_t   state_reg;
    tes_state_t   state_next;
    logic [15:0]  residual_reg;
    logic [15:0]  xst0_reg;
    logic [15:0]  xst0_next;
    logic         special_reg;
    tes_class_t   class_reg;
    tes_class_t   class_next;
    logic         let_enable_reg;
    logic [2:0]   irq_stat_reg;
    logic [2:0]   irq_mask_reg;
    logic         aw_held_reg;
    logic         w_held_reg;
    logic [7:0]   awaddr_reg;
    logic [31:0]  wdata_reg;
    logic [3:0]   wstrb_reg;

    // Class priority: a more severe class replaces a milder one, never the reverse.
    function automatic tes_class_t tes_worse(input tes_class_t a, input tes_class_t b);
        tes_worse = (b > a) ? b : a;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event decode.
    wire tes_event_t ev = xport_event;
    wire let_hit      = ev.skip_cmd & let_enable_reg & (ev.double_mark | ev.first_is_mark);
    wire short_hit    = ev.record_short | (ev.skip_cmd & ev.double_mark & let_enable_reg);
    wire wle_hit      = ev.write_no_ring | ev.write_lock_trip;
    wire cmd_active   = (state_reg == TES_BUSY) | ev.cmd_start;

    // Class contributed by this cycle's events; status-only inputs add nothing.
    tes_class_t ev_class;
    always_comb begin
        ev_class = `TES_TC_NORMAL;
        if (ev.attention) begin
            ev_class = tes_worse(ev_class, `TES_TC_ATTENTION);
        end
        if (ev.tape_mark_seen | short_hit | ev.record_long | let_hit) begin
            ev_class = tes_worse(ev_class, `TES_TC_STATUS_ALERT);
        end
        if (ev.offline_reject | ev.write_no_ring) begin
            ev_class = tes_worse(ev_class, `TES_TC_REJECT);
        end
        if (ev.recover_moved) begin
            ev_class = tes_worse(ev_class, `TES_TC_RECOVER_MOVED);
        end
        if (ev.write_lock_trip) begin
            ev_class = tes_worse(ev_class, `TES_TC_UNRECOVERABLE);
        end
        if (ev.fatal) begin
            ev_class = `TES_TC_FATAL;
        end
    end

    // Sticky extended status zero; a new command clears its latched flags.
    always_comb begin
        xst0_next = ev.cmd_start ? `TES_RESET_WORD : xst0_reg;
        if (cmd_active) begin
            xst0_next[`TES_X0_TAPE_MARK]      = xst0_next[`TES_X0_TAPE_MARK] | ev.tape_mark_seen;
            xst0_next[`TES_X0_REC_SHORT]      = xst0_next[`TES_X0_REC_SHORT] | short_hit;
            xst0_next[`TES_X0_LOGICAL_END]    = xst0_next[`TES_X0_LOGICAL_END] | let_hit;
            xst0_next[`TES_X0_REC_LONG]       = xst0_next[`TES_X0_REC_LONG] | ev.record_long;
            xst0_next[`TES_X0_WRITE_LOCK_ERR] = xst0_next[`TES_X0_WRITE_LOCK_ERR] | wle_hit;
        end
        class_next = ev.cmd_start ? `TES_TC_NORMAL : class_reg;
        if (cmd_active | ev.attention) begin
            class_next = tes_worse(class_next, ev_class);
        end
    end

    // Command tracking, Gray along idle, busy, done.
    always_comb begin
        case (state_reg)
            TES_IDLE: state_next = ev.cmd_start ? TES_BUSY : TES_IDLE;
            TES_BUSY: state_next = ev.cmd_done ? TES_DONE : TES_BUSY;
            TES_DONE: state_next = ev.cmd_start ? TES_BUSY : TES_IDLE;
            default:  state_next = TES_IDLE;
        endcase
    end

    // status only
    // Status-only levels are shown live and never touch the class field.
    wire [15:0] xst0_view = xst0_reg
                          | (16'h0001 << `TES_X0_ONLINE) & {16{xport_level.online_flag}}
                          | (16'h0001 << `TES_X0_WRITE_LOCKED) & {16{xport_level.write_locked}}
                          | (16'h0001 << `TES_X0_BOT) & {16{xport_level.beginning_of_tape}};
    wire [15:0] main_view = {special_reg, 11'h000, class_reg, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt sources: command done, attention, nonzero class.
    wire [2:0] irq_src = {ev.cmd_done & (class_next != `TES_TC_NORMAL), ev.attention, ev.cmd_done};
    assign irq = |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path; address and data may arrive in either order.
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
    wire        aw_now   = aw_held_reg | s_axi_awvalid;
    wire        w_now    = w_held_reg | s_axi_wvalid;
    wire [7:0]  wr_addr  = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data  = w_held_reg ? wdata_reg : s_axi_wdata;
    wire        wr_lane0 = w_held_reg ? wstrb_reg[0] : s_axi_wstrb[0];
    wire        wr_fire  = aw_now & w_now & ~s_axi_bvalid;
    wire        wr_char  = wr_fire & wr_lane0 & (wr_addr == `TES_OFF_CHAR);
    wire        wr_stat  = wr_fire & wr_lane0 & (wr_addr == `TES_OFF_IRQ_STATUS);
    wire        wr_mask  = wr_fire & wr_lane0 & (wr_addr == `TES_OFF_IRQ_MASK);
    wire        wr_known = wr_char | wr_stat | wr_mask;

    // read no effect
    // Read decode is pure selection; nothing in the bank reacts to a read.
    wire        rd_known = (s_axi_araddr <= `TES_OFF_IRQ_MASK) & (s_axi_araddr[1:0] == 2'b00);
    logic [15:0] rd_word;
    always_comb begin
        case (s_axi_araddr)
            `TES_OFF_MAIN_STATUS: rd_word = main_view;
            `TES_OFF_RESIDUAL:    rd_word = residual_reg;
            `TES_OFF_XST0:        rd_word = xst0_view;
            `TES_OFF_XST1:        rd_word = xport_level.xst1;
            `TES_OFF_XST2:        rd_word = xport_level.xst2;
            `TES_OFF_XST3:        rd_word = xport_level.xst3;
            `TES_OFF_CHAR:        rd_word = {15'h0000, let_enable_reg};
            `TES_OFF_IRQ_STATUS:  rd_word = {13'h0000, irq_stat_reg};
            `TES_OFF_IRQ_MASK:    rd_word = {13'h0000, irq_mask_reg};
            default:              rd_word = 16'h0000;
        endcase
    end
    assign s_axi_arready = ~s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // Status and command state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg   <= TES_IDLE;
            xst0_reg    <= `TES_RESET_WORD;
            class_reg   <= `TES_TC_NORMAL;
            special_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg   <= state_next;
            xst0_reg    <= xst0_next;
            class_reg   <= class_next;
            special_reg <= (class_next != `TES_TC_NORMAL);
        end
    end

    // residual load
    // Only commands that report a residual load it; others leave it stale.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            residual_reg <= `TES_RESET_WORD;
        end else if (clk_en && ev.residual_valid) begin
            residual_reg <= ev.residual;
        end
    end

    // Software registers; a new event wins over a write-one clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            let_enable_reg <= 1'b0;
            irq_stat_reg   <= 3'h0;
            irq_mask_reg   <= 3'h0;
        end else if (clk_en) begin
            if (wr_char) begin
                let_enable_reg <= wr_data[0];
            end
            if (wr_mask) begin
                irq_mask_reg <= wr_data[2:0];
            end
            irq_stat_reg <= (irq_stat_reg & ~({3{wr_stat}} & wr_data[2:0])) | irq_src;
        end
    end

    // Bus handshake state.
    // A channel that arrives alone is parked in a holding register until its partner comes;
    // this costs a few flip-flops but lets the host present address and data independently.
    // The answers stand until the host takes them, so a slow host never loses a response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {16'h0000, rd_word};
                s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: sim/tes_bank_props.sv */
// Port-level checks for the tape extended status register bank.
`timescale 1ns/10ps
module tes_bank_props
    import tes_pkg::*;
(
    input logic        aclk,
    input logic        aresetn,
    input logic        clk_en,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input tes_event_t  xport_event,
    input logic        irq
);
    // Everything here lives in the one clock domain and resets together.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////
    // A fresh reset leaves no answer pending and no interrupt.
    reset_idle_a : assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bank not idle after reset");
    read_latency_a : assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
        else $error("read answer late");
    write_latency_a : assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
        |=> s_axi_bvalid) else $error("write answer late");
    // Answers must wait for the host, otherwise a slow host loses data.
    read_hold_a : assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    write_hold_a : assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_block_a : assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    word_width_a : assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_rresp[0])
        else $error("read word too wide");
    // Without events or writes the interrupt must not move, so reads are harmless.
    irq_quiet_a : assert property (xport_event == '0 && !s_axi_awvalid && !s_axi_wvalid |=> $stable(irq))
        else $error("interrupt moved by itself");
    cover property (s_axi_rvalid && !s_axi_rready);
    cover property (s_axi_bvalid && !s_axi_bready);
    cover property ($rose(irq));
endmodule

bind tes_bank tes_bank_props tes_bank_props_i (.*);

/* File: sim/tes_host.sv */
// Host model that reaches the bank over AXI4-Lite.
`timescale 1ns/10ps
module tes_host (
    input  logic        aclk,
    output logic [7:0]  s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  logic        s_axi_wready,
    input  logic [1:0]  s_axi_bresp,
    input  logic        s_axi_bvalid,
    output logic        s_axi_bready,
    output logic [7:0]  s_axi_araddr,
    output logic        s_axi_arvalid,
    input  logic        s_axi_arready,
    input  logic [31:0] s_axi_rdata,
    input  logic [1:0]  s_axi_rresp,
    input  logic        s_axi_rvalid,
    output logic        s_axi_rready
);
    int stall = 0;

    // Idle bus at time zero; only full words are ever written.
    initial begin
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Each channel is released on its own edge; the stall delays the ready.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        repeat (stall) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read one word; data and response are taken at the answering edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat (stall) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

/* File: sim/tes_bank_test.sv */
// Self-checking bench for the tape extended status register bank.
`timescale 1ns/10ps
module tes_bank_test;
    import tes_pkg::*;
    logic        aclk, aresetn, clk_en, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    tes_event_t  xport_event;
    tes_level_t  xport_level;
    int          err_total = 0;
    int          comparisons = 0;

    tes_bank tes_bank_i (.*);
    tes_host tes_host_i (.*);

    // Free-running 100 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        tes_host_i.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        tes_host_i.wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // One command with one event in it; online stays high, so bit 6 shows.
    task automatic run(input logic [30:0] m, input logic [15:0] x0, input logic [2:0] c);
        xport_event <= tes_event_t'(31'h40000000);
        @(posedge aclk);
        xport_event <= tes_event_t'(m);
        @(posedge aclk);
        xport_event <= tes_event_t'(31'h20000000);
        @(posedge aclk);
        xport_event <= '0;
        @(posedge aclk);
        rdc(8'h08, {16'h0, x0 | 16'h0040}, 2'b00);
        rdc(8'h00, {16'h0, c != 3'h0, 11'h0, c, 1'b0}, 2'b00);
    endtask

    // The watchdog allows far more than the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        summarize();
    end

    // Main sequence: reset, register map, every event class, then the interrupt.
    initial begin
        aresetn = 1'b0;
        clk_en = 1'b1;
        xport_event = '0;
        xport_level = {3'b100, 16'h1111, 16'h2222, 16'h3333};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(8'h00, 32'h0, 2'b00);
        rdc(8'h04, 32'h0, 2'b00);
        rdc(8'h08, 32'h40, 2'b00);
        rdc(8'h0c, 32'h1111, 2'b00);
        rdc(8'h10, 32'h2222, 2'b00);
        rdc(8'h14, 32'h3333, 2'b00);
        tes_host_i.stall = 3;
        wrc(8'h04, 32'hffff, 2'b10);
        rdc(8'h04, 32'h0, 2'b00);
        rdc(8'h40, 32'h0, 2'b10);
        tes_host_i.stall = 0;
        run(31'h10000000, 16'h8000, 3'h2);
        run(31'h08000000, 16'h4000, 3'h2);
        run(31'h04000000, 16'h1000, 3'h2);
        run(31'h00400000, 16'h0800, 3'h3);
        run(31'h00200000, 16'h0800, 3'h6);
        run(31'h00100000, 16'h0000, 3'h1);
        run(31'h00080000, 16'h0000, 3'h3);
        run(31'h00040000, 16'h0000, 3'h4);
        run(31'h00020000, 16'h0000, 3'h7);
        run(31'h02800000, 16'h0000, 3'h0);
        run(31'h000100ab, 16'h0000, 3'h0);
        rdc(8'h04, 32'h00ab, 2'b00);
        wrc(8'h18, 32'h1, 2'b00);
        run(31'h02800000, 16'h6000, 3'h2);
        run(31'h01800000, 16'h2000, 3'h2);
        rdc(8'h08, 32'h2040, 2'b00);
        clk_en <= 1'b0;
        xport_event <= tes_event_t'(31'h40000000);
        @(posedge aclk);
        xport_event <= '0;
        clk_en <= 1'b1;
        @(posedge aclk);
        rdc(8'h08, 32'h2040, 2'b00);
        rdc(8'h1c, 32'h7, 2'b00);
        chk({31'h0, irq}, 32'h0);
        wrc(8'h20, 32'h4, 2'b00);
        chk({31'h0, irq}, 32'h1);
        wrc(8'h1c, 32'h4, 2'b00);
        chk({31'h0, irq}, 32'h0);
        rdc(8'h1c, 32'h3, 2'b00);
        summarize();
    end
endmodule
